//--- pkg/lsu_pkg.sv
// Purpose: shared types and constants for the load/store unit
// Assumes: 32-bit core, sixteen general-purpose registers
// Notes: register index 13 is the stack pointer, 15 the program counter
package lsu_pkg;
  localparam int LSU_XLEN = 32;
  localparam int LSU_NREG = 16;
  localparam logic [3:0] LSU_STACK_IDX = 4'hd;
  localparam logic [3:0] LSU_PC_IDX = 4'hf;
  localparam logic [3:0] LSU_LOW_MAX = 4'h7;
  localparam logic [31:0] LSU_WORD_BYTES = 32'h4;
  localparam logic [31:0] LSU_ZERO = 32'h0;
  localparam logic [31:0] LSU_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [15:0] LSU_MASK_NONE = 16'h0;

  typedef enum logic [1:0] {
    LSU_SZ_WORD = 2'h0,
    LSU_SZ_HALF = 2'h1,
    LSU_SZ_BYTE = 2'h2
  } lsu_size_t;

  typedef enum logic [2:0] {
    LSU_OP_LOAD = 3'h0,
    LSU_OP_STORE = 3'h1,
    LSU_LOAD_MULTIPLE_OP = 3'h2,
    LSU_STORE_MULTIPLE_OP = 3'h3,
    LSU_OP_PUSH = 3'h4,
    LSU_OP_POP = 3'h5
  } lsu_op_t;

  // one request from instruction execution
  typedef struct packed {
    lsu_op_t op;
    lsu_size_t size;
    logic sign_ext;
    logic [3:0] base_idx;
    logic [31:0] base_val;
    logic off_is_reg;
    logic [3:0] off_idx;
    logic [31:0] off_val;
    logic off_sub;
    logic [3:0] rd_idx;
    logic [31:0] st_data;
    logic [15:0] reg_list;
    logic writeback;
  } lsu_req_t;

  // data memory port request
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    lsu_size_t size;
  } lsu_mem_t;

  typedef enum logic [3:0] {
    LSU_ST_IDLE = 4'b0001,
    LSU_ST_SINGLE = 4'b0010,
    LSU_ST_MULTI = 4'b0100,
    LSU_ST_DONE = 4'b1000
  } lsu_state_t;
endpackage

//--- verilog/lsu_load_store_unit.sv
// Purpose: load/store unit, single and multi-register transfers
// Assumes: memory answers with mem_ack, one transfer in flight at a time
// Notes: register file sits outside; reads via rf_rd_*, writes via rf_wr_*
`timescale 1ns/1ns

// Contract
// - narrow stores write low 16 or 8 bits
// - signed and unsigned stores are identical
// - unsigned narrow loads zero-extend to 32
// - signed narrow loads sign-extend to 32
// - address is base plus offset
// - base is R0-R7, stack pointer, or PC
// - PC base allowed for loads only
// - immediate offset unsigned, added or subtracted
// - register offset not PC, added or subtracted
// - multi transfer moves selected register subset
// - multi transfer uses consecutive aligned words
// - writeback adds total transferred byte size
// - load/store multiple increment after base
// - push predecrements stack pointer, writes it back
// - pop into PC is interworking branch
// - interworking address needs bit zero set
// - stack pointer low two bits zero
module lsu_load_store_unit
  import lsu_pkg::*;
#(
  parameter int XLEN = LSU_XLEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request from execution
  input wire logic req_valid,
  input wire lsu_req_t req,
  output logic req_ready,
  output logic req_illegal,
  // register file read port for multi stores
  output logic [3:0] rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  // register file write port
  output logic rf_wr_en,
  output logic [3:0] rf_wr_idx,
  output logic [31:0] rf_wr_data,
  // program counter load
  output logic pc_load_write_function,
  output logic [31:0] pc_target,
  output logic pc_state_fault,
  // data memory port
  output lsu_mem_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // completion
  output logic done
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] lowest_set(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = LSU_NREG - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] count_bytes(input logic [15:0] m);
    logic [31:0] c;
    c = LSU_ZERO;
    for (int i = 0; i < LSU_NREG; i++) begin
      if (m[i]) begin
        c = c + LSU_WORD_BYTES;
      end
    end
    return c;
  endfunction

  // one decoder for both the incoming and the held request
  function automatic logic is_multi_cur(input lsu_op_t o);
    return (o == LSU_LOAD_MULTIPLE_OP) || (o == LSU_STORE_MULTIPLE_OP)
           || (o == LSU_OP_PUSH) || (o == LSU_OP_POP);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lsu_state_t state;
  lsu_req_t cur;
  logic [15:0] remain;
  logic [31:0] walk_addr;
  logic [31:0] wb_val;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire logic is_multi = is_multi_cur(req.op);
  wire logic is_loadish = (req.op == LSU_OP_LOAD);
  wire logic base_low = req.base_idx <= LSU_LOW_MAX;
  wire logic base_stack = req.base_idx == LSU_STACK_IDX;
  wire logic base_pc = req.base_idx == LSU_PC_IDX;
  wire logic bad_base = !(base_low || base_stack || base_pc);
  wire logic bad_pc = base_pc && !is_loadish;
  wire logic bad_off = req.off_is_reg && (req.off_idx == LSU_PC_IDX);
  wire logic bad_list = is_multi && (req.reg_list == LSU_MASK_NONE);
  wire logic illegal = bad_base || bad_pc || bad_off || bad_list;

  // stack pointer reads with its low two bits forced to zero
  wire logic [31:0] base_eff = base_stack ? (req.base_val & LSU_ALIGN_MASK)
                                       : req.base_val;
  wire logic [31:0] pc_aligned = req.base_val & LSU_ALIGN_MASK;
  wire logic [31:0] base_use = base_pc ? pc_aligned : base_eff;
  wire logic [31:0] off_use = req.off_val;
  wire logic [31:0] single_addr = req.off_sub ? base_use - off_use
                                              : base_use + off_use;
  wire logic [31:0] total = count_bytes(req.reg_list);
  wire logic is_push = req.op == LSU_OP_PUSH;
  wire logic is_pop = req.op == LSU_OP_POP;
  // push and pop always work on the aligned stack pointer
  wire logic [31:0] multi_base = (is_push || is_pop)
                                 ? (req.base_val & LSU_ALIGN_MASK)
                                 : (base_eff & LSU_ALIGN_MASK);
  wire logic [31:0] multi_start = is_push ? multi_base - total
                                          : multi_base;
  wire logic [31:0] multi_wb = is_push ? multi_start
                                       : multi_base + total;

  // ----------------------------------------------------------------
  // store data narrowing, same for signed and unsigned
  // ----------------------------------------------------------------
  // narrowed at take, so wdata stands from the first valid cycle
  wire logic [31:0] st_half = {16'h0, req.st_data[15:0]};
  wire logic [31:0] st_byte = {24'h0, req.st_data[7:0]};
  wire logic [31:0] st_narrow = (req.size == LSU_SZ_HALF) ? st_half
                              : (req.size == LSU_SZ_BYTE) ? st_byte
                              : req.st_data;

  // ----------------------------------------------------------------
  // load data widening
  // ----------------------------------------------------------------
  wire logic [31:0] ld_half = cur.sign_ext
    ? {{16{mem_rdata[15]}}, mem_rdata[15:0]}
    : {16'h0, mem_rdata[15:0]};
  wire logic [31:0] ld_byte = cur.sign_ext
    ? {{24{mem_rdata[7]}}, mem_rdata[7:0]}
    : {24'h0, mem_rdata[7:0]};
  wire logic [31:0] ld_value = (cur.size == LSU_SZ_HALF) ? ld_half
                             : (cur.size == LSU_SZ_BYTE) ? ld_byte
                             : mem_rdata;

  // ----------------------------------------------------------------
  // multi-register walk
  // ----------------------------------------------------------------
  wire logic [3:0] cur_reg = lowest_set(remain);
  wire logic [15:0] cur_bit = 16'h1 << cur_reg;
  wire logic [15:0] next_remain = remain & ~cur_bit;
  wire logic multi_store = (cur.op == LSU_STORE_MULTIPLE_OP)
                           || (cur.op == LSU_OP_PUSH);
  wire logic last_beat = next_remain == LSU_MASK_NONE;
  wire logic pop_pc = (cur.op == LSU_OP_POP) && (cur_reg == LSU_PC_IDX);
  wire logic [31:0] next_walk = walk_addr + LSU_WORD_BYTES;
  // base register updated by the transfer itself keeps the loaded value
  // push always moves the stack pointer, writeback bit or not; pop does too unless its list holds the base register
  wire logic stack_op = (cur.op == LSU_OP_PUSH) || (cur.op == LSU_OP_POP);
  wire logic wb_in_list = cur.reg_list[cur.base_idx];
  wire logic do_wb = (cur.writeback || stack_op)
                     && !(wb_in_list && !multi_store);

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= LSU_ST_IDLE;
      cur <= '0;
      remain <= LSU_MASK_NONE;
      walk_addr <= LSU_ZERO;
      wb_val <= LSU_ZERO;
      req_ready <= 1'b1;
      req_illegal <= 1'b0;
      rf_rd_idx <= 4'h0;
      rf_wr_en <= 1'b0;
      rf_wr_idx <= 4'h0;
      rf_wr_data <= LSU_ZERO;
      pc_load_write_function <= 1'b0;
      pc_target <= LSU_ZERO;
      pc_state_fault <= 1'b0;
      mem <= '0;
      done <= 1'b0;
    end else begin
      rf_wr_en <= 1'b0;
      pc_load_write_function <= 1'b0;
      pc_state_fault <= 1'b0;
      req_illegal <= 1'b0;
      done <= 1'b0;
      case (state)
        LSU_ST_IDLE: begin
          if (req_valid && illegal) begin
            req_illegal <= 1'b1;
          end else if (req_valid) begin
            cur <= req;
            req_ready <= 1'b0;
            remain <= req.reg_list;
            wb_val <= multi_wb;
            if (is_multi) begin
              walk_addr <= multi_start;
              rf_rd_idx <= lowest_set(req.reg_list);
              state <= LSU_ST_MULTI;
            end else begin
              mem.valid <= 1'b1;
              mem.write <= req.op == LSU_OP_STORE;
              mem.addr <= single_addr;
              mem.size <= req.size;
              mem.wdata <= st_narrow;
              state <= LSU_ST_SINGLE;
            end
          end
        end
        LSU_ST_SINGLE: begin
          if (mem_ack) begin
            mem.valid <= 1'b0;
            if (!mem.write) begin
              rf_wr_en <= 1'b1;
              rf_wr_idx <= cur.rd_idx;
              rf_wr_data <= ld_value;
            end
            state <= LSU_ST_DONE;
          end
        end
        LSU_ST_MULTI: begin
          if (!mem.valid) begin
            // issue one word per beat, register data read a cycle earlier
            mem.valid <= 1'b1;
            mem.write <= multi_store;
            mem.addr <= walk_addr;
            mem.size <= LSU_SZ_WORD;
            mem.wdata <= rf_rd_data;
          end else if (mem_ack) begin
            mem.valid <= 1'b0;
            remain <= next_remain;
            walk_addr <= next_walk;
            rf_rd_idx <= lowest_set(next_remain);
            if (!multi_store && pop_pc) begin
              pc_load_write_function <= 1'b1;
              pc_target <= mem_rdata;
              pc_state_fault <= !mem_rdata[0];
            end else if (!multi_store) begin
              rf_wr_en <= 1'b1;
              rf_wr_idx <= cur_reg;
              rf_wr_data <= mem_rdata;
            end
            if (last_beat) begin
              state <= LSU_ST_DONE;
            end
          end
        end
        LSU_ST_DONE: begin
          if (is_multi_cur(cur.op) && do_wb) begin
            rf_wr_en <= 1'b1;
            rf_wr_idx <= cur.base_idx;
            rf_wr_data <= wb_val & ((cur.base_idx == LSU_STACK_IDX)
                          ? LSU_ALIGN_MASK : ~LSU_ZERO);
          end
          done <= 1'b1;
          req_ready <= 1'b1;
          state <= LSU_ST_IDLE;
        end
        default: begin
          state <= LSU_ST_IDLE;
          req_ready <= 1'b1;
          mem <= '0;
        end
      endcase
    end
  end

endmodule

//--- tb/lsu_load_store_unit_chk.sv
// Purpose: port assertions for the load/store unit
// Assumes: one request in flight at a time
// Notes: attached to every unit instance by bind
`timescale 1ns/1ns
module lsu_chk
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request side
  input wire logic req_valid,
  input wire lsu_req_t req,
  input wire logic req_ready,
  input wire logic req_illegal,
  input wire logic done,
  // pc load
  input wire logic pc_load_write_function,
  input wire logic [31:0] pc_target,
  input wire logic pc_state_fault,
  // memory side
  input wire lsu_mem_t mem,
  input wire logic mem_ack
);
  // ----
  // helpers
  // ----
  logic multi;
  logic seen;
  logic [31:0] last;
  wire take = req_valid && req_ready;
  wire sgl = req.op inside {LSU_OP_LOAD, LSU_OP_STORE};
  wire [31:0] ea = req.off_sub ? req.base_val - req.off_val
                               : req.base_val + req.off_val;
  wire hi_base = req.base_idx > LSU_LOW_MAX &&
    req.base_idx != LSU_STACK_IDX && req.base_idx != LSU_PC_IDX;
  // a refused transfer list keeps multi set, harmless: no access follows
  always_ff @(posedge clk) begin
    multi <= sys_rst ? 1'b0 : take ? !sgl : done ? 1'b0 : multi;
    seen <= (sys_rst || take) ? 1'b0 : (mem_ack && multi) ? 1'b1 : seen;
    last <= (mem.valid && mem_ack) ? mem.addr : last;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_high_base: assert property (
    take && sgl && hi_base |=> req_illegal)
    else $error("high base register accepted");
  a_pc_store: assert property (
    take && req.op == LSU_OP_STORE && req.base_idx == LSU_PC_IDX
    |=> req_illegal) else $error("store off pc accepted");
  a_pc_offset: assert property (
    take && sgl && req.off_is_reg && req.off_idx == LSU_PC_IDX
    |=> req_illegal) else $error("pc offset accepted");
  a_imm_addr: assert property (
    take && sgl && req.base_idx <= LSU_LOW_MAX
    && !(req.off_is_reg && req.off_idx == LSU_PC_IDX)
    |=> mem.valid && mem.addr == $past(ea)) else $error("bad address");
  a_addr_hold: assert property (
    mem.valid && !mem_ack |=> mem.valid && $stable(mem.addr))
    else $error("access dropped before ack");
  a_wdata_hold: assert property (
    mem.valid && !mem_ack |=> $stable(mem.wdata) && $stable(mem.write))
    else $error("store data moved before ack");
  a_multi_step: assert property (
    multi && seen && $rose(mem.valid) |-> mem.addr == last + 32'h4)
    else $error("list address not stepping by four");
  a_word_align: assert property (
    multi && mem.valid |-> mem.addr[1:0] == 2'h0)
    else $error("list access not aligned");
  a_narrow_data: assert property (
    mem.valid && mem.write && mem.size != LSU_SZ_WORD
    |-> mem.wdata[31:16] == 16'h0 &&
    (mem.size == LSU_SZ_HALF || mem.wdata[15:8] == 8'h0))
    else $error("narrow store upper bits set");
  a_fault_flag: assert property (
    pc_load_write_function |-> pc_state_fault == !pc_target[0])
    else $error("state fault wrong");
endmodule

bind lsu_load_store_unit lsu_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .req_illegal(req_illegal), .done(done),
  .pc_load_write_function(pc_load_write_function),
  .pc_target(pc_target), .pc_state_fault(pc_state_fault),
  .mem(mem), .mem_ack(mem_ack));

//--- tb/lsu_mem_model.sv
// Purpose: data memory partner for the load/store unit bench
// Assumes: sixteen words, indexed by address bits 5:2
// Notes: slow adds three wait cycles before each ack
`timescale 1ns/1ns
module lsu_mem_model
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data port
  input wire lsu_mem_t mem,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [16];
  logic [31:0] last;
  logic [1:0] cnt;
  wire [31:0] word = ram[mem.addr[5:2]];
  wire busy = mem.valid && !mem_ack;
  // read data only holds with the ack, so a late sample sees garbage
  assign mem_rdata = mem_ack ? word : ~last;
  always @(posedge clk) begin
    mem_ack <= !sys_rst && busy && cnt == (slow ? 2'h3 : 2'h0);
    cnt <= (busy && !sys_rst) ? cnt + 2'h1 : 2'h0;
    if (sys_rst) last <= 32'h0;
    else if (mem.valid && mem_ack) last <= word;
    if (mem.valid && mem_ack && mem.write) ram[mem.addr[5:2]] <= mem.wdata;
  end
endmodule

//--- tb/lsu_load_store_unit_tb.sv
// Purpose: self-checking bench for the load/store unit
// Assumes: register file modelled here, memory in lsu_mem_model
// Notes: each scenario is one task
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module lsu_load_store_unit_tb;
  import lsu_pkg::*;
  logic clk, sys_rst, req_valid, slow, req_ready, req_illegal, done;
  logic rf_wr_en, pc_load_write_function, pc_state_fault, mem_ack;
  lsu_req_t req;
  lsu_mem_t mem;
  logic [3:0] rf_rd_idx, rf_wr_idx;
  logic [31:0] rf_wr_data, pc_target, mem_rdata, pc_got;
  logic [31:0] rf_got [16];
  logic flt_got;
  int n_fail, checked, n_ill;
  function automatic logic [31:0] rv(logic [3:0] i);
    return 32'ha5a5_a500 | {28'h0, i};
  endfunction
  wire [31:0] rf_rd_data = rv(rf_rd_idx);
  lsu_load_store_unit uut (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_illegal(req_illegal), .rf_rd_idx(rf_rd_idx),
    .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx),
    .rf_wr_data(rf_wr_data), .pc_load_write_function(pc_load_write_function),
    .pc_target(pc_target), .pc_state_fault(pc_state_fault), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done));
  lsu_mem_model mdl (.clk(clk), .sys_rst(sys_rst), .mem(mem), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rf_wr_en) rf_got[rf_wr_idx] <= rf_wr_data;
    if (pc_load_write_function) pc_got <= pc_target;
    if (pc_load_write_function) flt_got <= pc_state_fault;
    if (req_illegal) n_ill <= n_ill + 1;
  end
  // ----
  // helpers
  // ----
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic mk(lsu_op_t op, logic [3:0] b, logic [31:0] bv,
    logic [15:0] l);
    req = '{op: op, size: LSU_SZ_WORD, base_idx: b, base_val: bv,
      reg_list: l, default: '0};
  endtask
  // one request, then wait for done or refusal under a bound
  task automatic go();
    int i;
    @(posedge clk) #1 req_valid = 1'b1;
    @(posedge clk) #1 req_valid = 1'b0;
    for (i = 0; i < 80; i++) begin
      if (done === 1'b1 || req_illegal === 1'b1) break;
      @(posedge clk) #1;
    end
    if (i == 80) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk) #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_store();
    for (int k = 0; k < 4; k++) begin
      mk(LSU_OP_STORE, 4'h1, 32'h20, LSU_MASK_NONE);
      req.size = k[1] ? LSU_SZ_BYTE : LSU_SZ_HALF;
      req.sign_ext = k[0];
      req.off_sub = k[0];
      req.off_val = 32'h4;
      req.st_data = 32'hc3b2_a190;
      go();
      `CHK("store", k[1] ? 32'h90 : 32'ha190, mdl.ram[k[0] ? 7 : 9])
    end
    mk(LSU_OP_STORE, 4'h2, 32'h10, LSU_MASK_NONE);
    req.off_is_reg = 1'b1;
    req.off_idx = 4'h3;
    req.off_val = 32'h8;
    req.st_data = 32'h1234_5678;
    go();
    `CHK("store_reg", 32'h1234_5678, mdl.ram[6])
    $display("store test over");
  endtask
  task automatic t_load();
    logic [31:0] exp [5] = '{32'h1234_8080, 32'h8080, 32'hffff_8080,
      32'h80, 32'hffff_ff80};
    mdl.ram[2] = 32'h1234_8080;
    for (int k = 0; k < 5; k++) begin
      mk(LSU_OP_LOAD, LSU_PC_IDX, 32'h6, LSU_MASK_NONE);
      req.off_val = 32'h4;
      req.rd_idx = 4'h5;
      req.size = lsu_size_t'((k + 1) / 2);
      req.sign_ext = (k != 0) && !k[0];
      go();
      `CHK("load", exp[k], rf_got[5])
    end
    $display("load test over");
  endtask
  task automatic t_bad();
    int n0 = n_ill;
    mk(LSU_OP_LOAD, 4'h9, 32'h0, LSU_MASK_NONE);
    go();
    mk(LSU_OP_STORE, LSU_PC_IDX, 32'h8, LSU_MASK_NONE);
    go();
    mk(LSU_OP_LOAD, 4'h1, 32'h0, LSU_MASK_NONE);
    req.off_is_reg = 1'b1;
    req.off_idx = LSU_PC_IDX;
    go();
    mk(LSU_LOAD_MULTIPLE_OP, 4'h1, 32'h0, LSU_MASK_NONE);
    go();
    `CHK("refused", n0 + 4, n_ill)
    $display("refusal test over");
  endtask
  task automatic t_multi();
    slow = 1'b1;
    mk(LSU_STORE_MULTIPLE_OP, 4'h2, 32'h20, 16'h0092);
    req.writeback = 1'b1;
    go();
    `CHK("list_st0", rv(4'h1), mdl.ram[8])
    `CHK("list_st1", rv(4'h4), mdl.ram[9])
    `CHK("list_st2", rv(4'h7), mdl.ram[10])
    `CHK("list_st_wb", 32'h2c, rf_got[2])
    mk(LSU_LOAD_MULTIPLE_OP, 4'h3, 32'h20, 16'h0021);
    req.writeback = 1'b1;
    go();
    `CHK("list_ld0", rv(4'h1), rf_got[0])
    `CHK("list_ld5", rv(4'h4), rf_got[5])
    `CHK("list_ld_wb", 32'h28, rf_got[3])
    slow = 1'b0;
    $display("list test over");
  endtask
  task automatic t_stack();
    mk(LSU_OP_PUSH, LSU_STACK_IDX, 32'h33, 16'h0009);
    go();
    `CHK("push0", rv(4'h0), mdl.ram[10])
    `CHK("push3", rv(4'h3), mdl.ram[11])
    `CHK("push_stack", 32'h28, rf_got[13])
    for (int k = 0; k < 2; k++) begin
      mdl.ram[11] = 32'h101 - k;
      mk(LSU_OP_POP, LSU_STACK_IDX, 32'h28, 16'h8001);
      go();
      `CHK("pop_r0", rv(4'h0), rf_got[0])
      `CHK("pop_pc", 32'h101 - k, pc_got)
      `CHK("pop_fault", k[0], flt_got)
      `CHK("pop_stack", 32'h30, rf_got[13])
    end
    $display("stack test over");
  endtask
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    slow = 1'b0;
    req = '0;
    n_fail = 0;
    checked = 0;
    n_ill = 0;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    `CHK("ready", 1'b1, req_ready)
    t_store();
    t_load();
    t_bad();
    t_multi();
    t_stack();
    wrap_up();
  end
endmodule
